// file: hdl/fcaos_pkg.sv
/*
 * Constants, register map and load-state encoding of the flash command
 * address and option-byte status register bank.
 * Assumes an APB slave with 32-bit data, one aligned word per register.
 */
// Contract
// - Command address: 32-bit, writable, word access only
// - Option data field loads into bits 25:10
// - Option user field loads into bits 9:2
// - Bit 1 shows security protection active
// - Bit 0 flags option byte complement mismatch
// - Mismatched option byte is replaced by all ones
package fcaos_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] FCAOS_OFF_CMD_ADDR = 8'h14;  // Command address, write only
    localparam logic [7:0] FCAOS_OFF_OB_STAT = 8'h1C;   // Option-byte status, read only
    localparam logic [7:0] FCAOS_OFF_IRQ_STAT = 8'h30;  // Sticky event bits, write one to clear
    localparam logic [7:0] FCAOS_OFF_IRQ_MASK = 8'h34;  // Event enables, same layout

    // ------------------------------------------------------------
    // Option-byte status field positions
    // ------------------------------------------------------------
    localparam int FCAOS_OB_DATA_HI = 25;   // Data field top bit
    localparam int FCAOS_OB_DATA_LO = 10;   // Data field bottom bit
    localparam int FCAOS_OB_USER_HI = 9;    // User field top bit
    localparam int FCAOS_OB_USER_LO = 2;    // User field bottom bit
    localparam int FCAOS_OB_PROT_BIT = 1;   // Security protection flag
    localparam int FCAOS_OB_ERR_BIT = 0;    // Option load error flag

    // ------------------------------------------------------------
    // Event bit positions in status and mask registers
    // ------------------------------------------------------------
    localparam int FCAOS_EV_LOAD_ERR = 0;   // Option load found a mismatch
    localparam int FCAOS_EV_ADDR_WR = 1;    // Command address was written
    localparam int FCAOS_EV_NUM = 2;        // Number of event bits

    // ------------------------------------------------------------
    // Reset values and fixed patterns
    // ------------------------------------------------------------
    localparam logic [31:0] FCAOS_RST_CMD_ADDR = 32'h0000_0000;  // Command address after reset
    localparam logic [31:0] FCAOS_RST_OB_STAT = 32'h0000_0000;   // Status before the load
    localparam logic [31:0] FCAOS_RST_RDATA = 32'h0000_0000;     // Read data idle value
    localparam logic [1:0] FCAOS_RST_EVENTS = 2'h0;              // Events and mask after reset
    localparam logic [3:0] FCAOS_STRB_WORD = 4'hF;               // Full word byte enables
    localparam logic [5:0] FCAOS_OB_RSVD = 6'h00;                // Bits 31:26 read as zero

    // ------------------------------------------------------------
    // Option-byte load sequence
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        FCAOS_LD_PENDING = 1'b0,    // Waiting to capture the option bytes
        FCAOS_LD_DONE = 1'b1        // Status holds the checked option bytes
    } fcaos_load_t;

endpackage

// file: hdl/fcaos_ob_check.sv
/*
 * Complement check of one option-byte field.
 * Assumes the value and its stored complement are stable while sampled.
 */
`timescale 1ns/100ps
module fcaos_ob_check #(
    parameter int WIDTH = 8
) (
    input wire logic [WIDTH-1:0] rawValue,
    input wire logic [WIDTH-1:0] rawCompl,
    output logic [WIDTH-1:0] checkedValue,
    output logic mismatch
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (WIDTH < 1) begin : g_bad_width
        $error("fcaos_ob_check: WIDTH must be at least one");
    end

    // ------------------------------------------------------------
    // Check and substitution
    // ------------------------------------------------------------
    // Field and complement must be exact bitwise inverses
    assign mismatch = (rawValue != ~rawCompl);
    assign checkedValue = mismatch ? {WIDTH{1'b1}} : rawValue;

endmodule // fcaos_ob_check

// file: hdl/fcaos_top.sv
/*
 * Flash command address register and option-byte status register, with
 * two sticky events (load error, address written) on one interrupt line.
 * Assumes an APB master on clk, option-byte contents on plain inputs that
 * are stable after reset, and a flash engine that reads cmdTargetAddr.
 */
`timescale 1ns/100ps
module fcaos_top #(
    parameter int APB_AW = 8,
    parameter logic [7:0] UNPROT_KEY = 8'h5A  // Arbitrary value: key meaning unprotected
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] obSecurity,
    input wire logic [7:0] obSecurityCmp,
    input wire logic [7:0] obUser,
    input wire logic [7:0] obUserCmp,
    input wire logic [7:0] obDataLo,
    input wire logic [7:0] obDataLoCmp,
    input wire logic [7:0] obDataHi,
    input wire logic [7:0] obDataHiCmp,
    output logic [31:0] cmdTargetAddr,
    output logic irq
);
    import fcaos_pkg::*;

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    // Offsets need eight address bits to decode
    if (APB_AW < 8 || APB_AW > 32) begin : g_bad_aw
        $error("fcaos_top: APB_AW must lie in 8..32");
    end

    // A corrupt security byte reads all ones and must count as protected
    if (UNPROT_KEY == 8'hFF) begin : g_bad_key
        $error("fcaos_top: UNPROT_KEY must differ from all ones");
    end

    // ------------------------------------------------------------
    // State of the block
    // ------------------------------------------------------------
    typedef struct packed {
        fcaos_load_t loadState;                 // Option-byte load progress
        logic [31:0] cmdAddr;                   // Command target address
        logic [31:0] obStat;                    // Option-byte status image
        logic [FCAOS_EV_NUM-1:0] evStat;        // Sticky events
        logic [FCAOS_EV_NUM-1:0] evMask;        // Event enables
        logic [31:0] rdData;                    // Read data for the access phase
        logic busErr;                           // Error answer for the access phase
        logic captured;                         // Request taken, access may complete
    } fcaos_state_t;

    fcaos_state_t q;            // Registered state
    fcaos_state_t d;            // Next state

    // ------------------------------------------------------------
    // Option-byte complement checks
    // ------------------------------------------------------------
    logic [7:0] secChecked;     // Security byte after check
    logic [7:0] userChecked;    // User byte after check
    logic [7:0] dataLoChecked;  // Data low byte after check
    logic [7:0] dataHiChecked;  // Data high byte after check
    logic secBad;               // Security byte mismatch
    logic userBad;              // User byte mismatch
    logic dataLoBad;            // Data low byte mismatch
    logic dataHiBad;            // Data high byte mismatch
    logic anyBad;               // Any field mismatched
    logic protActive;           // Protection in force

    // Security field check
    fcaos_ob_check #(
        .WIDTH(8)
    ) u_chk_sec (
        .rawValue(obSecurity),
        .rawCompl(obSecurityCmp),
        .checkedValue(secChecked),
        .mismatch(secBad)
    );

    // User field check
    fcaos_ob_check #(
        .WIDTH(8)
    ) u_chk_user (
        .rawValue(obUser),
        .rawCompl(obUserCmp),
        .checkedValue(userChecked),
        .mismatch(userBad)
    );

    // Data low byte check
    fcaos_ob_check #(
        .WIDTH(8)
    ) u_chk_dlo (
        .rawValue(obDataLo),
        .rawCompl(obDataLoCmp),
        .checkedValue(dataLoChecked),
        .mismatch(dataLoBad)
    );

    // Data high byte check
    fcaos_ob_check #(
        .WIDTH(8)
    ) u_chk_dhi (
        .rawValue(obDataHi),
        .rawCompl(obDataHiCmp),
        .checkedValue(dataHiChecked),
        .mismatch(dataHiBad)
    );

    assign anyBad = secBad | userBad | dataLoBad | dataHiBad;
    // protection decode; a corrupt byte reads all ones, so protects
    assign protActive = (secChecked != UNPROT_KEY);

    // ------------------------------------------------------------
    // Bus phase decode
    // ------------------------------------------------------------
    logic setupPh;      // APB setup cycle
    logic accessPh;     // APB access cycle, completes when clkEn is high
    logic hitCmd;       // Address selects command address
    logic hitOb;        // Address selects option status
    logic hitStat;      // Address selects event status
    logic hitMask;      // Address selects event mask
    logic fullWord;     // All byte lanes enabled
    logic wrDone;       // Write completes this edge without error
    logic accessDone;   // Access completes this edge
    logic [FCAOS_EV_NUM-1:0] evSet;     // Events raised this cycle
    logic [FCAOS_EV_NUM-1:0] evClr;     // Events cleared by software

    assign setupPh = psel & ~penable;
    assign accessPh = psel & penable;
    assign hitCmd = (paddr == APB_AW'(FCAOS_OFF_CMD_ADDR));
    assign hitOb = (paddr == APB_AW'(FCAOS_OFF_OB_STAT));
    assign hitStat = (paddr == APB_AW'(FCAOS_OFF_IRQ_STAT));
    assign hitMask = (paddr == APB_AW'(FCAOS_OFF_IRQ_MASK));
    assign fullWord = (pstrb == FCAOS_STRB_WORD);
    // Access ends only once its request has been taken
    assign accessDone = accessPh & q.captured;
    assign wrDone = accessDone & pwrite & ~q.busErr;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        evSet = '0;
        evClr = '0;
        if (clkEn) begin
            // Load of the option bytes, once after each reset
            case (q.loadState)
                FCAOS_LD_PENDING: begin
                    d.obStat[FCAOS_OB_DATA_HI:FCAOS_OB_DATA_LO] = {dataHiChecked, dataLoChecked};
                    d.obStat[FCAOS_OB_USER_HI:FCAOS_OB_USER_LO] = userChecked;
                    d.obStat[FCAOS_OB_PROT_BIT] = protActive;
                    d.obStat[FCAOS_OB_ERR_BIT] = anyBad;
                    d.obStat[31:26] = FCAOS_OB_RSVD;
                    evSet[FCAOS_EV_LOAD_ERR] = anyBad;
                    d.loadState = FCAOS_LD_DONE;
                end
                default: begin
                    // Status stays as loaded until the next reset
                    d.loadState = FCAOS_LD_DONE;
                end
            endcase

            // Setup cycle: pick read data and error answer; a setup cycle
            // lost to a low clkEn is taken up in the first enabled access
            if (setupPh || (accessPh && !q.captured)) begin
                d.captured = 1'b1;
                if (hitCmd) begin
                    // Write only: reads return zero
                    d.rdData = FCAOS_RST_RDATA;
                    d.busErr = pwrite & ~fullWord;
                end else if (hitOb) begin
                    d.rdData = q.obStat;
                    d.busErr = pwrite;
                end else if (hitStat) begin
                    d.rdData = {30'h0000_0000, q.evStat};
                    d.busErr = pwrite & ~fullWord;
                end else if (hitMask) begin
                    d.rdData = {30'h0000_0000, q.evMask};
                    d.busErr = pwrite & ~fullWord;
                end else begin
                    // Unmapped address
                    d.rdData = FCAOS_RST_RDATA;
                    d.busErr = 1'b1;
                end
            end

            // Access cycle: writes take effect here
            if (wrDone) begin
                if (hitCmd) begin
                    d.cmdAddr = pwdata;
                    evSet[FCAOS_EV_ADDR_WR] = 1'b1;
                end else if (hitStat) begin
                    evClr = pwdata[FCAOS_EV_NUM-1:0];
                end else if (hitMask) begin
                    d.evMask = pwdata[FCAOS_EV_NUM-1:0];
                end
            end

            // Completed access frees the slot for the next setup
            if (accessDone) begin
                d.captured = 1'b0;
            end

            // Sticky events: a new event beats a clear in the same cycle
            d.evStat = (q.evStat & ~evClr) | evSet;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            q.loadState <= FCAOS_LD_PENDING;
            q.cmdAddr <= FCAOS_RST_CMD_ADDR;
            q.obStat <= FCAOS_RST_OB_STAT;
            q.evStat <= FCAOS_RST_EVENTS;
            q.evMask <= FCAOS_RST_EVENTS;
            q.rdData <= FCAOS_RST_RDATA;
            q.busErr <= 1'b0;
            q.captured <= 1'b0;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Zero-wait answer once taken; a frozen block holds the master off
    assign pready = clkEn & q.captured;
    assign prdata = q.rdData;
    assign pslverr = q.busErr;
    assign cmdTargetAddr = q.cmdAddr;
    assign irq = |(q.evStat & q.evMask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // Data field view for the load check
    logic [15:0] obStatData;
    assign obStatData = q.obStat[FCAOS_OB_DATA_HI:FCAOS_OB_DATA_LO];

    // Completed full-word write to the command address
    sequence seqAddrWrite;
        psel && penable && pwrite && clkEn && q.captured && !q.busErr && hitCmd;
    endsequence

    // Edge at which the option bytes are captured
    sequence seqLoad;
        (q.loadState == FCAOS_LD_PENDING) && clkEn;
    endsequence

    // Setup of a partial write to the command address
    sequence seqPartial;
        psel && !penable && pwrite && clkEn && hitCmd && !fullWord;
    endsequence

    AST_ADDR_STORE: assert property (seqAddrWrite |=> cmdTargetAddr == $past(pwdata))
        else $error("Command address did not take the written word");

    AST_ADDR_PARTIAL: assert property (seqPartial ##1 (psel && penable) |=>
        pslverr && $stable(cmdTargetAddr))
        else $error("Partial write to command address was not refused");

    AST_ADDR_HOLD: assert property (!(psel && penable && pwrite && hitCmd) |=>
        $stable(cmdTargetAddr))
        else $error("Command address changed without a write");

    AST_DATA_LOAD: assert property (seqLoad |=>
        obStatData == $past({dataHiChecked, dataLoChecked}) && q.loadState == FCAOS_LD_DONE)
        else $error("Option data field not loaded into bits 25:10");

    AST_USER_LOAD: assert property (seqLoad |=>
        q.obStat[FCAOS_OB_USER_HI:FCAOS_OB_USER_LO] == $past(userChecked))
        else $error("Option user field not loaded into bits 9:2");

    AST_PROT_FLAG: assert property (seqLoad |=>
        q.obStat[FCAOS_OB_PROT_BIT] == ($past(secChecked) != UNPROT_KEY))
        else $error("Protection flag disagrees with security byte");

    AST_ERR_FLAG: assert property (seqLoad ##0 anyBad |=>
        q.obStat[FCAOS_OB_ERR_BIT] && q.evStat[FCAOS_EV_LOAD_ERR] ##1 q.obStat[FCAOS_OB_ERR_BIT])
        else $error("Load error flag or event missing after mismatch");

    AST_FF_SUBST: assert property (seqLoad ##0 userBad |=>
        q.obStat[FCAOS_OB_USER_HI:FCAOS_OB_USER_LO] == 8'hFF)
        else $error("Mismatched user byte not replaced by all ones");

    AST_STATUS_STABLE: assert property ((q.loadState == FCAOS_LD_DONE) |=> $stable(q.obStat))
        else $error("Option status changed after the load");

    // ------------------------------------------------------------
    // Freeze, status read, event and load detail checks
    // ------------------------------------------------------------
    AST_FROZEN_HOLD: assert property (!clkEn |=>
        $stable(cmdTargetAddr) && $stable(q.evStat))
        else $error("State moved while the clock enable was low");

    AST_OB_READ: assert property (psel && !penable && !pwrite && clkEn && hitOb |=>
        prdata == $past(q.obStat))
        else $error("Status read did not return the option status");

    AST_FF_DATA: assert property (seqLoad ##0 dataLoBad |=>
        q.obStat[FCAOS_OB_DATA_LO+7:FCAOS_OB_DATA_LO] == 8'hFF)
        else $error("Mismatched data low byte not replaced by all ones");

    AST_PROT_BAD: assert property (seqLoad ##0 secBad |=> q.obStat[FCAOS_OB_PROT_BIT])
        else $error("Corrupt security byte did not show protection");

    AST_ADDR_EVENT: assert property (seqAddrWrite |=> q.evStat[FCAOS_EV_ADDR_WR])
        else $error("Address write did not raise its event");

    AST_OB_RSVD: assert property ((q.loadState == FCAOS_LD_DONE) |->
        q.obStat[31:26] == FCAOS_OB_RSVD)
        else $error("Reserved status bits are not zero");

endmodule // fcaos_top

// file: verif/flash_cmd_addr_option_status_test.sv
/*
 * Self-checking bench for the flash command address and option status bank.
 * Assumes fcaos_pkg and fcaos_top are compiled first and that a 100 MHz clock suffices.
 */
`timescale 1ns/100ps
module flash_cmd_addr_option_status_test;
    import fcaos_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [7:0] KEY = 8'h5A;  // Arbitrary value: unprotected key
    logic clk = 1'b0;  // Bus clock
    logic srst = 1'b1;  // Reset held from time zero
    logic clkEn = 1'b1;  // Clock enable, frozen by one scenario
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] obSec = 8'h00, obSecC = 8'h00, obUsr = 8'h00, obUsrC = 8'h00;
    logic [7:0] obDl = 8'h00, obDlC = 8'h00, obDh = 8'h00, obDhC = 8'h00;
    logic [31:0] cmdTargetAddr;
    logic irq;
    logic [31:0] rd;  // Last read data
    logic er;  // Last error response
    int errors = 0;
    int check_count = 0;

    // Clock of 10 ns period
    always #5 clk = ~clk;

    fcaos_top #(.APB_AW(8), .UNPROT_KEY(KEY)) dut (
        .clk(clk), .srst(srst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .obSecurity(obSec), .obSecurityCmp(obSecC), .obUser(obUsr), .obUserCmp(obUsrC),
        .obDataLo(obDl), .obDataLoCmp(obDlC), .obDataHi(obDh), .obDataHiCmp(obDhC),
        .cmdTargetAddr(cmdTargetAddr), .irq(irq)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    // Compare a register value
    task chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Compare a single flag
    task chkFlag(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; holds the request until pready is seen high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        if (n >= 50) begin
            errors++;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reset with given option bytes; the first edge after release loads them
    task load(input logic [7:0] sc, sc2, us, us2, dl, dl2, dh, dh2);
        @(posedge clk);
        srst <= 1'b1;
        {obSec, obSecC, obUsr, obUsrC} <= {sc, sc2, us, us2};
        {obDl, obDlC, obDh, obDhC} <= {dl, dl2, dh, dh2};
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk(cmdTargetAddr, FCAOS_RST_CMD_ADDR);
        chkFlag(irq, 1'b0);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Clean option bytes, unprotected key
    task test_load_good;
        load(KEY, ~KEY, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h81, 8'h7E);
        apb(1'b0, FCAOS_OFF_OB_STAT, 32'h0000_0000, 4'hF);
        chk(rd, {6'h00, 8'h81, 8'h3C, 8'hA5, 1'b0, 1'b0});
        chkFlag(er, 1'b0);
        apb(1'b0, FCAOS_OFF_IRQ_STAT, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000);
    endtask

    // Address writes, refusals and the address-written event
    task test_addr;
        apb(1'b1, FCAOS_OFF_CMD_ADDR, 32'hFFFF_FFFF, 4'hF);
        apb(1'b1, FCAOS_OFF_CMD_ADDR, 32'hDEAD_BEEF, 4'hF);
        chkFlag(er, 1'b0);
        @(negedge clk);
        chk(cmdTargetAddr, 32'hDEAD_BEEF);
        apb(1'b0, FCAOS_OFF_CMD_ADDR, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0000);
        // Partial word write is refused and leaves the address alone
        apb(1'b1, FCAOS_OFF_CMD_ADDR, 32'h1234_5678, 4'h3);
        chkFlag(er, 1'b1);
        @(negedge clk);
        chk(cmdTargetAddr, 32'hDEAD_BEEF);
        // Status is read only
        apb(1'b1, FCAOS_OFF_OB_STAT, 32'hFFFF_FFFF, 4'hF);
        chkFlag(er, 1'b1);
        apb(1'b0, FCAOS_OFF_OB_STAT, 32'h0000_0000, 4'hF);
        chk(rd, {6'h00, 8'h81, 8'h3C, 8'hA5, 1'b0, 1'b0});
        // Unmapped address
        apb(1'b0, 8'h40, 32'h0000_0000, 4'hF);
        chkFlag(er, 1'b1);
        // Event raised, masked, unmasked and cleared
        apb(1'b0, FCAOS_OFF_IRQ_STAT, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0002);
        chkFlag(irq, 1'b0);
        apb(1'b1, FCAOS_OFF_IRQ_MASK, 32'h0000_0002, 4'hF);
        @(negedge clk);
        chkFlag(irq, 1'b1);
        apb(1'b1, FCAOS_OFF_IRQ_STAT, 32'h0000_0002, 4'hF);
        @(negedge clk);
        chkFlag(irq, 1'b0);
    endtask

    // Status read with the block frozen through its setup and first two access cycles
    task test_freeze;
        @(posedge clk);
        clkEn <= 1'b0;
        fork
            apb(1'b0, FCAOS_OFF_OB_STAT, 32'h0000_0000, 4'hF);
            begin
                repeat (4) @(posedge clk);
                chkFlag(pready, 1'b0);
                chk(cmdTargetAddr, 32'hDEAD_BEEF);
                clkEn <= 1'b1;
            end
        join
        chk(rd, {6'h00, 8'h81, 8'h3C, 8'hA5, 1'b0, 1'b0});
        chkFlag(er, 1'b0);
    endtask

    // Complement mismatch on security and data low bytes
    task test_bad;
        load(KEY, 8'h00, 8'h12, 8'hED, 8'h3C, 8'h00, 8'h81, 8'h7E);
        apb(1'b0, FCAOS_OFF_OB_STAT, 32'h0000_0000, 4'hF);
        chk(rd, {6'h00, 8'h81, 8'hFF, 8'h12, 1'b1, 1'b1});
        apb(1'b0, FCAOS_OFF_IRQ_STAT, 32'h0000_0000, 4'hF);
        chk(rd, 32'h0000_0001);
        apb(1'b1, FCAOS_OFF_IRQ_MASK, 32'h0000_0001, 4'hF);
        @(negedge clk);
        chkFlag(irq, 1'b1);
        apb(1'b1, FCAOS_OFF_IRQ_STAT, 32'h0000_0001, 4'hF);
        @(negedge clk);
        chkFlag(irq, 1'b0);
    endtask

    // ----------------------------------------
    // Verdict and run control
    // ----------------------------------------
    // Prints the counts and the verdict, then ends the run
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        test_load_good();
        test_addr();
        test_freeze();
        test_bad();
        finish_test();
    end

    // Watchdog well beyond the few dozen cycles the tests need
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        finish_test();
    end
endmodule  // flash_cmd_addr_option_status_test
